// ===== verilog/pls_lock_top.sv
// How it works
// R1: the detector gives a lock verdict only at the end of each reference period.
// R2: the controller waits two reference periods after a new divisor before judging lock.
// R3: a detected unlock holds the flag until the next serial transaction, even after relock.
// R4: the controller treats the first readout after a divisor change as a dummy.
// R5: in unlock-indication mode the status pin is high when locked and low when unlocked.
// R6: dead-zone codes 0 and 1 pass every pump pulse, codes 2 and 3 swallow short ones.
// R7: the status pin shows serial data, counter completion, unlock state or an input level.
// R8: the controller forces the tuning voltage briefly when the oscillator may stop.
// R9: the controller counts only after it sees the station-detect indication.
// R10: the width select stops detection, passes raw phase error or uses a stretched window.
// R11: while unlocked the pin is pulled low and the serial flag reads zero.
// R12: the serial flag reads one when locked since the last serial transaction or when detection is stopped.
// R13: the force bit drives the charge pump to a fixed level instead of normal operation.
`timescale 1ns/1ps
`include "pls_lock_map.svh"

module pls_lock_top
   import pls_lock_pkg::*;
#(
   parameter int STRETCH_CYC = `PLS_STRETCH_CYC
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ref_tick,
   input  wire logic        phase_err,
   input  wire logic        serial_txn,
   input  wire logic        serial_data,
   input  wire logic        if_count_done,
   input  wire logic        pass_in,
   input  wire logic        station_detect,
   input  wire logic        pump_up_req,
   input  wire logic        pump_dn_req,
   output logic             pump_up,
   output logic             pump_dn,
   output logic             charge_pump_force_o,
   output logic             status_pin_o,
   output logic             status_pin_oe,
   output logic             unlock_flag,
   output logic             irq
);

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   logic [1:0] rst_pipe_q;
   logic       rst_sync_n;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe_q <= 2'h0;
      else
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
   end

   assign rst_sync_n = rst_pipe_q[1];

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed
   {
      logic [1:0]  unlock_width_select;
      pls_dz_t     dead_zone_select;
      logic        charge_pump_force;
      pls_pin_t    pin_sel;
      logic [1:0]  int_stat;
      logic [1:0]  int_mask;
      logic        seen;
      logic        det_unl;
      logic        hold_unl;
      logic [1:0]  up_hist;
      logic [1:0]  dn_hist;
      logic        up;
      logic        dn;
      logic        pin_oe;
      logic        irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } pls_state_t;

   pls_state_t s_q;
   pls_state_t s_d;
   logic       err_live;

   pls_err_detect #(
      .STRETCH_CYC (STRETCH_CYC)
   ) i_pls_err_detect (
      .clk_sys             (clk_sys),
      .rst_sync_n          (rst_sync_n),
      .phase_err           (phase_err),
      .unlock_width_select (s_q.unlock_width_select),
      .err_live            (err_live)
   );

   // pulse shaping; codes 0 and 1 have no dead zone, it widens with codes 2 and 3
   function automatic logic pump_shape(input pls_dz_t dz,
                                       input logic    req,
                                       input logic [1:0] hist);
      unique case (dz)
         no_gap_mode_a: pump_shape = req;
         no_gap_mode_b: pump_shape = req;
         gap_mode_c:    pump_shape = req & hist[0];
         gap_mode_d:    pump_shape = req & hist[0] & hist[1];
      endcase
   endfunction

   function automatic logic [31:0] read_mux(input pls_state_t s,
                                            input logic [7:0] a,
                                            input logic       live,
                                            input logic       sd);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `PLS_OFS_CTRL:
         begin
            r[`PLS_CTRL_UW_LSB +: 2]  = s.unlock_width_select;
            r[`PLS_CTRL_DZ_LSB +: 2]  = s.dead_zone_select;
            r[`PLS_CTRL_FORCE]        = s.charge_pump_force;
            r[`PLS_CTRL_PIN_LSB +: 3] = s.pin_sel;
         end
         `PLS_OFS_STATUS:
         begin
            r[`PLS_ST_UNLOCK_FLAG] = !s.hold_unl; // R12
            r[`PLS_ST_DET_LOCKED]  = !s.det_unl;
            r[`PLS_ST_STATION]     = sd;
            r[`PLS_ST_ERR_LIVE]    = live;
         end
         `PLS_OFS_INT_STAT: r[1:0] = s.int_stat;
         `PLS_OFS_INT_MASK: r[1:0] = s.int_mask;
         default:           r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return a == `PLS_OFS_CTRL || a == `PLS_OFS_STATUS ||
             a == `PLS_OFS_INT_STAT || a == `PLS_OFS_INT_MASK;
   endfunction

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   logic       wr_en;
   logic       verdict;
   logic [1:0] ev;
   logic       pin_lvl;

   always_comb
   begin
      s_d = s_q;
      wr_en = psel && penable && s_q.pready && pwrite && addr_ok(paddr);

      // apb: no wait state, answer registered
      s_d.pready  = psel && !penable;
      s_d.pslverr = psel && !penable && !addr_ok(paddr);
      if (psel && !penable && !pwrite)
         s_d.prdata = read_mux(s_q, paddr, err_live, station_detect);

      if (wr_en && paddr == `PLS_OFS_CTRL)
      begin
         s_d.unlock_width_select = pwdata[`PLS_CTRL_UW_LSB +: 2];
         s_d.dead_zone_select    = pls_dz_t'(pwdata[`PLS_CTRL_DZ_LSB +: 2]);
         s_d.charge_pump_force   = pwdata[`PLS_CTRL_FORCE];
         s_d.pin_sel             = pls_pin_t'(pwdata[`PLS_CTRL_PIN_LSB +: 3]);
      end
      if (wr_en && paddr == `PLS_OFS_INT_MASK)
         s_d.int_mask = pwdata[1:0];

      // errors are gathered over one reference period, judged at its end
      verdict = s_q.seen || err_live;
      if (ref_tick)
      begin
         s_d.det_unl = verdict; // R1
         s_d.seen    = 1'b0;
      end
      else if (err_live)
         s_d.seen = 1'b1;
      if (s_q.unlock_width_select == 2'h0)
      begin
         s_d.det_unl = 1'b0; // R12
         s_d.seen    = 1'b0;
      end

      // sticky flag: reloaded by a transaction, set wins over the reload
      if (serial_txn)
         s_d.hold_unl = s_d.det_unl; // R3
      if (s_d.det_unl)
         s_d.hold_unl = 1'b1; // R3
      // stopped detection reads as locked, whatever was held before
      if (s_q.unlock_width_select == 2'h0)
         s_d.hold_unl = 1'b0; // R12

      ev = 2'h0;
      ev[`PLS_INT_UNLOCK] = s_d.det_unl && !s_q.det_unl;
      ev[`PLS_INT_RELOCK] = !s_d.det_unl && s_q.det_unl;
      if (wr_en && paddr == `PLS_OFS_INT_STAT)
         s_d.int_stat = s_q.int_stat & ~pwdata[1:0];
      s_d.int_stat = s_d.int_stat | ev;
      s_d.irq = |(s_d.int_stat & s_d.int_mask);

      // charge pump
      s_d.up_hist = {s_q.up_hist[0], pump_up_req};
      s_d.dn_hist = {s_q.dn_hist[0], pump_dn_req};
      if (s_q.charge_pump_force)
      begin
         s_d.up = 1'b1; // R13
         s_d.dn = 1'b0; // R13
      end
      else
      begin
         s_d.up = pump_shape(s_q.dead_zone_select, pump_up_req,
                             s_q.up_hist); // R6
         s_d.dn = pump_shape(s_q.dead_zone_select, pump_dn_req,
                             s_q.dn_hist); // R6
      end

      // open drain status pin: enable means pulled low
      pin_lvl = 1'b1;
      unique case (s_q.pin_sel)
         pls_pin_serial:  pin_lvl = serial_data; // R7
         pls_pin_if_done: pin_lvl = if_count_done; // R7
         pls_pin_unlock:  pin_lvl = !err_live; // R5 R11
         pls_pin_pass:    pin_lvl = pass_in; // R7
         default:         pin_lvl = 1'b1;
      endcase
      s_d.pin_oe = !pin_lvl;
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         s_q <= '0;
         s_q.unlock_width_select <= `PLS_RST_UW;
         s_q.dead_zone_select    <= pls_dz_t'(`PLS_RST_DZ);
         s_q.charge_pump_force   <= `PLS_RST_FORCE;
         s_q.pin_sel             <= pls_pin_t'(`PLS_RST_PIN);
         s_q.int_stat            <= `PLS_RST_INT;
         s_q.int_mask            <= `PLS_RST_INT;
      end
      else
         s_q <= s_d;
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         unlock_flag <= 1'b1;
      else
         unlock_flag <= !s_d.hold_unl; // R11 R12
   end

   assign prdata              = s_q.prdata;
   assign pready              = s_q.pready;
   assign pslverr             = s_q.pslverr;
   assign pump_up             = s_q.up;
   assign pump_dn             = s_q.dn;
   assign charge_pump_force_o = s_q.charge_pump_force;
   assign status_pin_o        = 1'b0;
   assign status_pin_oe       = s_q.pin_oe;
   assign irq                 = s_q.irq;

endmodule

// ===== verilog/pls_lock_map.svh
`ifndef PLS_LOCK_MAP_SVH
`define PLS_LOCK_MAP_SVH

// -----------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------
`define PLS_OFS_CTRL      8'h00
`define PLS_OFS_STATUS    8'h04
`define PLS_OFS_INT_STAT  8'h08
`define PLS_OFS_INT_MASK  8'h0c

// -----------------------------------------------------------------
// control field positions
// -----------------------------------------------------------------
`define PLS_CTRL_UW_LSB   0
`define PLS_CTRL_DZ_LSB   2
`define PLS_CTRL_FORCE    4
`define PLS_CTRL_PIN_LSB  5

// -----------------------------------------------------------------
// status and interrupt bit positions
// -----------------------------------------------------------------
`define PLS_ST_UNLOCK_FLAG  0
`define PLS_ST_DET_LOCKED   1
`define PLS_ST_STATION      2
`define PLS_ST_ERR_LIVE     3
`define PLS_INT_UNLOCK      0
`define PLS_INT_RELOCK      1

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define PLS_RST_UW        2'h0
`define PLS_RST_DZ        2'h0
`define PLS_RST_FORCE     1'h0
`define PLS_RST_PIN       3'h4
`define PLS_RST_INT       2'h0

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define PLS_CLK_NS        50
`define PLS_WIN_NS        6670
`define PLS_WIN_CYC       ((`PLS_WIN_NS + `PLS_CLK_NS - 1) / `PLS_CLK_NS)
`define PLS_STRETCH_NS    1000000
`define PLS_STRETCH_CYC   ((`PLS_STRETCH_NS + `PLS_CLK_NS - 1) / `PLS_CLK_NS)

`endif

// ===== verilog/pls_lock_pkg.sv
package pls_lock_pkg;

   typedef enum logic [1:0]
   {
      no_gap_mode_a,
      no_gap_mode_b,
      gap_mode_c,
      gap_mode_d
   } pls_dz_t;

   typedef enum logic [2:0]
   {
      pls_pin_serial,
      pls_pin_if_done,
      pls_pin_unlock,
      pls_pin_pass,
      pls_pin_open,
      pls_pin_open5,
      pls_pin_open6,
      pls_pin_open7
   } pls_pin_t;

endpackage

// ===== verilog/pls_err_detect.sv
`timescale 1ns/1ps
`include "pls_lock_map.svh"

module pls_err_detect
   import pls_lock_pkg::*;
#(
   parameter int STRETCH_CYC = `PLS_STRETCH_CYC
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst_sync_n,
   input  wire logic       phase_err,
   input  wire logic [1:0] unlock_width_select,
   output logic            err_live
);

   localparam logic [7:0]  WIN_CYC = 8'(`PLS_WIN_CYC);
   localparam logic [15:0] STR_CYC = 16'(STRETCH_CYC);

   typedef struct packed
   {
      logic [7:0]  width;
      logic [15:0] stretch;
   } pls_det_state_t;

   pls_det_state_t s_q;
   pls_det_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (phase_err && s_q.width != WIN_CYC)
         s_d.width = s_q.width + 8'h01;
      else if (!phase_err)
         s_d.width = 8'h00;
      // wide error reloads the stretch; the stretch restarts on each one
      if (phase_err && s_q.width == WIN_CYC)
         s_d.stretch = STR_CYC; // R10
      else if (s_q.stretch != 16'h0000)
         s_d.stretch = s_q.stretch - 16'h0001;
      if (!unlock_width_select[1])
         s_d.stretch = 16'h0000;
      unique case (unlock_width_select)
         2'h0:    err_live = 1'b0; // R10
         2'h1:    err_live = phase_err; // R10
         default: err_live = s_q.stretch != 16'h0000; // R10
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

endmodule

// ===== bench/pls_lock_monitor.sv
`timescale 1ns/1ps
module pls_lock_monitor
#(
   parameter int STRETCH_CYC = 1
)
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        ref_tick,
   input wire logic        phase_err,
   input wire logic        serial_txn,
   input wire logic        pass_in,
   input wire logic        serial_data,
   input wire logic        if_count_done,
   input wire logic        pump_up_req,
   input wire logic        pump_dn_req,
   input wire logic        pump_up,
   input wire logic        pump_dn,
   input wire logic        charge_pump_force_o,
   input wire logic        status_pin_o,
   input wire logic        status_pin_oe,
   input wire logic        unlock_flag,
   input wire logic        irq
);
   logic [7:0] ctrl_q;
   // ---
   // control shadow: mirrors accepted writes, so modes are known
   // ---
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         ctrl_q <= 8'h80;
      else if (psel && penable && pready && pwrite && paddr == 8'h00)
         ctrl_q <= pwdata[7:0];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_flag_falls: assert property (
      $fell(unlock_flag) |-> $past(ref_tick)) else $error("early fall");
   chk_flag_held: assert property (
      $rose(unlock_flag) |-> $past(serial_txn) || ctrl_q[1:0] == 2'h0)
      else $error("flag released without transaction");
   chk_pin_live: assert property (
      ctrl_q[7:5] == 3'h2 && ctrl_q[1:0] == 2'h1
      |=> status_pin_oe == $past(phase_err)) else $error("pin not live");
   chk_det_stopped: assert property (
      (ctrl_q[1:0] == 2'h0)[*3] |-> unlock_flag
      && (ctrl_q[7:5] != 3'h2 || !status_pin_oe)) else $error("not stopped");
   chk_pin_pass: assert property (
      ctrl_q[7:5] == 3'h3 |=> status_pin_oe == !$past(pass_in))
      else $error("pass level wrong");
   chk_pin_serial: assert property (
      ctrl_q[7:5] == 3'h0 |=> status_pin_oe == !$past(serial_data))
      else $error("serial level wrong");
   chk_pin_count: assert property (
      ctrl_q[7:5] == 3'h1 |=> status_pin_oe == !$past(if_count_done))
      else $error("count done level wrong");
   chk_pin_open: assert property (
      ctrl_q[7] |=> !status_pin_oe && !status_pin_o) else $error("not open");
   chk_pump_track: assert property (
      !ctrl_q[4] && !ctrl_q[3] |=> pump_up == $past(pump_up_req)
      && pump_dn == $past(pump_dn_req)) else $error("pump not passed");
   chk_pump_gap: assert property (
      !ctrl_q[4] && ctrl_q[3] && !$past(pump_up_req) |=> !pump_up)
      else $error("short pulse passed");
   chk_pump_force: assert property (
      ctrl_q[4] |-> charge_pump_force_o ##1 (pump_up && !pump_dn))
      else $error("force ignored");
   cover property ($fell(unlock_flag));
   cover property ($rose(irq));
   cover property (ctrl_q[4] && pump_up);
endmodule

bind pls_lock_top pls_lock_monitor #(.STRETCH_CYC(STRETCH_CYC)) i_mon (
   .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .ref_tick, .phase_err, .serial_txn, .pass_in, .serial_data,
   .if_count_done, .pump_up_req, .pump_dn_req,
   .pump_up, .pump_dn, .charge_pump_force_o, .status_pin_o, .status_pin_oe,
   .unlock_flag, .irq);

// ===== bench/pls_ctrl_model.sv
`timescale 1ns/1ps
module pls_ctrl_model
#(
   parameter int REF_CYC = 20
)
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic txn_req,
   output logic      ref_tick,
   output logic      serial_txn
);
   int         cnt_q;
   logic [1:0] seen_q;
   logic       pend_q;
   // ---
   // reference period and delayed serial readout
   // ---
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
      begin
         cnt_q <= 0;
         seen_q <= 2'h0;
         pend_q <= 1'b0;
         ref_tick <= 1'b0;
         serial_txn <= 1'b0;
      end
      else
      begin
         cnt_q <= (cnt_q == REF_CYC - 1) ? 0 : cnt_q + 1;
         ref_tick <= cnt_q == REF_CYC - 1;
         // lock judged only two periods after the change
         serial_txn <= pend_q && seen_q == 2'h2;
         if (txn_req)
            {pend_q, seen_q} <= 3'h4;
         else if (pend_q && seen_q == 2'h2)
            pend_q <= 1'b0;
         else if (ref_tick && seen_q != 2'h2)
            seen_q <= seen_q + 2'h1;
      end
endmodule

// ===== bench/pls_lock_top_tb.sv
`timescale 1ns/1ps
`include "pls_lock_map.svh"
module pls_lock_top_tb;
   logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h5c65ed11;
   logic pready, pslverr, ref_tick, serial_txn, pump_up, pump_dn, irq;
   logic charge_pump_force_o, status_pin_o, status_pin_oe, unlock_flag;
   logic phase_err = 0, serial_data = 0, if_count_done = 0, pass_in = 0;
   logic station_detect = 0, pump_up_req = 0, pump_dn_req = 0, txn_req = 0;
   int err_count = 0, total_checks = 0;
   logic [31:0] exp_q[$], msk_q[$];
   always #25 clk_sys = ~clk_sys;
   pls_lock_top #(.STRETCH_CYC(300)) i_pls_lock_top (.clk_sys, .rst_n,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ref_tick, .phase_err, .serial_txn, .serial_data, .if_count_done,
      .pass_in, .station_detect, .pump_up_req, .pump_dn_req, .pump_up,
      .pump_dn, .charge_pump_force_o, .status_pin_o, .status_pin_oe,
      .unlock_flag, .irq);
   pls_ctrl_model #(.REF_CYC(20)) i_pls_ctrl_model (.clk_sys, .rst_n,
      .txn_req, .ref_tick, .serial_txn);
   // ---
   // shared tasks
   // ---
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      // idle edge first: a following call never drives psel twice at once
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         while (ref_tick !== 1'b1)
            @(posedge clk_sys);
      end
      repeat (4) @(posedge clk_sys);
   endtask
   // read data compared against the oldest note
   always @(posedge clk_sys)
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         chk(prdata & msk_q.pop_front(), exp_q.pop_front());
         chk({31'h0, pslverr}, {31'h0, paddr > 8'h0c});
      end
   initial
   begin
      #1000000;
      err_count++;
      tally_and_finish;
   end
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(unlock_flag, 1);
      rd(`PLS_OFS_CTRL, 32'h80, '1);
      rd(8'h10, 32'h0, '1);
      rd(`PLS_OFS_INT_MASK, 32'h0, '1);
      apb(1'b1, `PLS_OFS_CTRL, 32'h41);
      phase_err <= 1'b1;
      tick(1);
      chk(unlock_flag, 0);
      chk(status_pin_oe, 1);
      rd(`PLS_OFS_INT_STAT, 32'h1, 32'h1);
      apb(1'b1, `PLS_OFS_INT_MASK, 32'h1);
      repeat (3) @(posedge clk_sys);
      chk(irq, 1);
      apb(1'b1, `PLS_OFS_INT_STAT, 32'h1);
      phase_err <= 1'b0;
      tick(2);
      chk(irq, 0);
      chk(unlock_flag, 0);
      rd(`PLS_OFS_STATUS, 32'h2, 32'hf);
      rd(`PLS_OFS_INT_STAT, 32'h2, 32'h3);
      txn_req <= 1'b1;
      @(posedge clk_sys);
      txn_req <= 1'b0;
      tick(2);
      chk(unlock_flag, 1);
      rd(`PLS_OFS_STATUS, 32'h3, 32'hf);
      for (int i = 0; i < 16; i++)
      begin
         apb(1'b1, `PLS_OFS_CTRL, {24'h0, i[2:0], i[3], i[1:0], 2'h1});
         repeat (12)
         begin
            @(posedge clk_sys);
            rnd = lfsr(rnd);
            {phase_err, serial_data, pass_in, station_detect, pump_up_req,
               pump_dn_req} <= {rnd[6:5], rnd[3:0]};
            // count completion only reported with a station present
            if_count_done <= rnd[4] & rnd[2];
         end
         chk(charge_pump_force_o, i[3]);
      end
      apb(1'b1, `PLS_OFS_CTRL, 32'h42);
      phase_err <= 1'b1;
      repeat (150) @(posedge clk_sys);
      phase_err <= 1'b0;
      rd(`PLS_OFS_STATUS, 32'h8, 32'h8);
      chk(status_pin_oe, 1);
      apb(1'b1, `PLS_OFS_CTRL, 32'h40);
      phase_err <= 1'b1;
      tick(2);
      chk(unlock_flag, 1);
      chk(status_pin_oe, 0);
      tally_and_finish;
   end
endmodule
